// file: include/acmp_defines.vh
`ifndef ACMP_DEFINES_VH
`define ACMP_DEFINES_VH

// register byte offsets
`define ACMP_OFS_CONTROL     5'h00
`define ACMP_OFS_REFSEL      5'h04
`define ACMP_OFS_IRQ_STATUS  5'h08
`define ACMP_OFS_IRQ_MASK    5'h0c
`define ACMP_OFS_OUT_MODE    5'h10

// control register fields
`define ACMP_CTL_ENABLE      7
`define ACMP_CTL_RESULT      6
`define ACMP_CTL_INVERT      4
`define ACMP_CTL_NEG_HI      3
`define ACMP_CTL_NEG_LO      1
`define ACMP_CTL_POS         0

// reference select register fields
`define ACMP_REF_FORCE_PIN   7
`define ACMP_REF_RANGE_HI    5
`define ACMP_REF_RANGE_LO    4
`define ACMP_REF_TAP_HI      3
`define ACMP_REF_TAP_LO      0

// output mode register field
`define ACMP_MODE_SAMPLED    0

// negative input codes
`define ACMP_NEG_PIN3        3'h0
`define ACMP_NEG_PIN4        3'h1
`define ACMP_NEG_BANDGAP     3'h2
`define ACMP_NEG_LADDER      3'h3
`define ACMP_NEG_PIN6        3'h4

// positive input codes
`define ACMP_POS_LADDER      1'h0
`define ACMP_POS_PIN4        1'h1

// ladder ranges
`define ACMP_RANGE_QUARTER   2'h0
`define ACMP_RANGE_LOW24     2'h1
`define ACMP_RANGE_FIFTH     2'h2
`define ACMP_RANGE_LOW32     2'h3
`define ACMP_LADDER_OFFSET   6'h09
`define ACMP_DEN_32          6'h20
`define ACMP_DEN_24          6'h18
`define ACMP_DEN_40          6'h28

// reset values
`define ACMP_RST_CONTROL     8'h00
`define ACMP_RST_REFSEL      8'h00
`define ACMP_RST_MASK        8'h00
`define ACMP_RST_MODE        8'h00

// writable masks
`define ACMP_CTL_WMASK       8'h9f
`define ACMP_REF_WMASK       8'hbf

`endif

// file: rtl/acmp_top.v
`timescale 1ns/1ps
`include "acmp_defines.vh"
// What this block does
// - control bits 3:1 pick negative input: pin3, pin4, pin6, bandgap, ladder
// - control bit 0 picks positive input: pin4 or ladder reference
// - top control bit enables; code 000 is pin3, bit0 clear is ladder
// - invert set, code 011, bit0 set: inverted, ladder negative, pin4 positive
// - select bit 7 forces the result onto port a pin0 regardless of direction
// - forwarded result is direct or sampled on the timer2 clock
// - control bit 4 inverts comparator output polarity
// - output readable at control bit 6 and usable as interrupt source
// - select bits 5:4 choose ladder top and bottom, four configurations
// - select bits 3:0 pick one of sixteen equal ladder taps
// - range 00: reference is quarter supply plus (n+1)/32 supply
// - range 10: reference is fifth supply plus (n+1)/40 supply
// - reference spans one thirty-second to three quarters of supply
// - interrupt flag set by hardware, cleared only by software
module acmp_top (
	// clock and reset
	input  wire        clk_in,
	input  wire        reset_n_in,
	// avalon-mm slave
	input  wire [4:0]  avs_address_in,
	input  wire        avs_read_in,
	input  wire        avs_write_in,
	input  wire [3:0]  avs_byteenable_in,
	input  wire [31:0] avs_writedata_in,
	output wire [31:0] avs_readdata_out,
	output wire        avs_waitrequest_out,
	// interrupt
	output wire        irq_out,
	// analog comparator
	input  wire        comparator_raw_in,
	output wire        comparator_enable_out,
	output wire [2:0]  negative_select_out,
	output wire        positive_select_out,
	output wire [1:0]  ladder_range_out,
	output wire [3:0]  ladder_tap_out,
	output wire [5:0]  ladder_numerator_out,
	output wire [5:0]  ladder_denominator_out,
	// timer2 sample clock
	input  wire        timer2_sample_clock_in,
	// port a pin0
	input  wire        gpio_pin0_out_in,
	input  wire        gpio_pin0_oe_n_in,
	output wire        port_a_pin0_out,
	output wire        port_a_pin0_oe_n_out,
	output wire        comparator_result_bit_out
);

	reg  [7:0]  control_q;
	reg  [7:0]  refsel_q;
	reg  [7:0]  status_q;
	reg  [7:0]  status_d;
	reg  [7:0]  mask_q;
	reg  [7:0]  mode_q;
	reg         ack_q;
	reg  [31:0] readdata_q;
	reg  [7:0]  read_mux;
	reg         sync1_q;
	reg         sync2_q;
	reg         adjusted_q;
	reg         tm2_prev_q;
	reg         sampled_q;
	reg         forwarded_q;
	reg  [5:0]  num_q;
	reg  [5:0]  den_q;
	reg  [5:0]  num_d;
	reg  [5:0]  den_d;
	wire        request;
	wire        access;
	wire        wr_lane0;
	wire        adjusted_d;
	wire        change_event;
	wire [7:0]  status_clear;

	// ladder fraction of supply for a range and tap
	function [11:0] ladder_frac;
		input [1:0] range;
		input [3:0] tap;
		reg   [5:0] n;
		begin
			n = {2'h0, tap};
			case (range)
				`ACMP_RANGE_QUARTER: begin
					ladder_frac = {n + `ACMP_LADDER_OFFSET, `ACMP_DEN_32};
				end
				`ACMP_RANGE_LOW24: begin
					ladder_frac = {n + 6'h01, `ACMP_DEN_24};
				end
				`ACMP_RANGE_FIFTH: begin
					ladder_frac = {n + `ACMP_LADDER_OFFSET, `ACMP_DEN_40};
				end
				default: begin
					ladder_frac = {n + 6'h01, `ACMP_DEN_32};
				end
			endcase
		end
	endfunction

	// bus handshake: one wait cycle per access
	assign request             = avs_read_in | avs_write_in;
	assign access              = request & ack_q;
	assign wr_lane0            = access & avs_write_in & avs_byteenable_in[0];
	assign avs_waitrequest_out = request & ~ack_q;
	assign avs_readdata_out    = readdata_q;

	always @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= request & ~ack_q;
		end
	end

	// read multiplexer
	always @* begin
		read_mux = 8'h00;
		case (avs_address_in)
			`ACMP_OFS_CONTROL: begin
				read_mux = control_q;
				read_mux[`ACMP_CTL_RESULT] = adjusted_q;
			end
			`ACMP_OFS_REFSEL: begin
				read_mux = refsel_q;
			end
			`ACMP_OFS_IRQ_STATUS: begin
				read_mux = status_q;
			end
			`ACMP_OFS_IRQ_MASK: begin
				read_mux = mask_q;
			end
			`ACMP_OFS_OUT_MODE: begin
				read_mux = mode_q;
			end
			default: begin
				read_mux = 8'h00;
			end
		endcase
	end

	always @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			readdata_q <= 32'h00000000;
		end else if (avs_read_in & ~ack_q) begin
			readdata_q <= {24'h000000, read_mux};
		end
	end

	// software registers
	always @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			control_q <= `ACMP_RST_CONTROL;
			refsel_q  <= `ACMP_RST_REFSEL;
			mask_q    <= `ACMP_RST_MASK;
			mode_q    <= `ACMP_RST_MODE;
		end else if (wr_lane0) begin
			case (avs_address_in)
				`ACMP_OFS_CONTROL: begin
					control_q <= avs_writedata_in[7:0] & `ACMP_CTL_WMASK;
				end
				`ACMP_OFS_REFSEL: begin
					refsel_q <= avs_writedata_in[7:0] & `ACMP_REF_WMASK;
				end
				`ACMP_OFS_IRQ_MASK: begin
					mask_q <= {7'h00, avs_writedata_in[0]};
				end
				`ACMP_OFS_OUT_MODE: begin
					mode_q <= {7'h00, avs_writedata_in[`ACMP_MODE_SAMPLED]};
				end
				default: begin
					mode_q <= mode_q;
				end
			endcase
		end
	end

	// input selections to the analog core
	assign comparator_enable_out = control_q[`ACMP_CTL_ENABLE];
	assign negative_select_out   = control_q[`ACMP_CTL_NEG_HI:`ACMP_CTL_NEG_LO];
	assign positive_select_out   = control_q[`ACMP_CTL_POS];
	assign ladder_range_out      = refsel_q[`ACMP_REF_RANGE_HI:`ACMP_REF_RANGE_LO];
	assign ladder_tap_out        = refsel_q[`ACMP_REF_TAP_HI:`ACMP_REF_TAP_LO];

	always @* begin
		{num_d, den_d} = ladder_frac(ladder_range_out, ladder_tap_out);
	end

	always @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			num_q <= `ACMP_LADDER_OFFSET;
			den_q <= `ACMP_DEN_32;
		end else begin
			num_q <= num_d;
			den_q <= den_d;
		end
	end

	assign ladder_numerator_out   = num_q;
	assign ladder_denominator_out = den_q;

	// result synchroniser and polarity
	always @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			sync1_q <= 1'b0;
			sync2_q <= 1'b0;
		end else begin
			sync1_q <= comparator_raw_in;
			sync2_q <= sync1_q;
		end
	end

	assign adjusted_d = (sync2_q & control_q[`ACMP_CTL_ENABLE])
		^ control_q[`ACMP_CTL_INVERT];
	assign change_event = adjusted_d ^ adjusted_q;

	// timer2 sampling and forwarding
	always @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			adjusted_q  <= 1'b0;
			tm2_prev_q  <= 1'b0;
			sampled_q   <= 1'b0;
			forwarded_q <= 1'b0;
		end else begin
			adjusted_q <= adjusted_d;
			tm2_prev_q <= timer2_sample_clock_in;
			if (timer2_sample_clock_in & ~tm2_prev_q) begin
				sampled_q <= adjusted_q;
			end
			forwarded_q <= mode_q[`ACMP_MODE_SAMPLED] ? sampled_q : adjusted_q;
		end
	end

	assign comparator_result_bit_out = forwarded_q;
	assign port_a_pin0_out      = refsel_q[`ACMP_REF_FORCE_PIN] ? forwarded_q
		: gpio_pin0_out_in;
	assign port_a_pin0_oe_n_out = refsel_q[`ACMP_REF_FORCE_PIN] ? 1'b0
		: gpio_pin0_oe_n_in;

	// sticky status, set wins over clear
	assign status_clear = (access & avs_read_in & (avs_address_in == `ACMP_OFS_IRQ_STATUS))
		? 8'hff : 8'h00;

	always @* begin
		status_d    = status_q & ~status_clear;
		status_d[0] = status_d[0] | change_event;
	end

	always @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			status_q <= 8'h00;
		end else begin
			status_q <= status_d;
		end
	end

	assign irq_out = |(status_q & mask_q);

endmodule // acmp_top

// file: sim/acmp_top_sva.sv
`timescale 1ns/1ps
module acmp_top_sva (
	input wire       clk_in,
	input wire       reset_n_in,
	input wire       avs_read_in,
	input wire       avs_write_in,
	input wire       avs_waitrequest_out,
	input wire       irq_out,
	input wire       comparator_raw_in,
	input wire [2:0] negative_select_out,
	input wire       positive_select_out,
	input wire [1:0] ladder_range_out,
	input wire [3:0] ladder_tap_out,
	input wire [5:0] ladder_numerator_out,
	input wire [5:0] ladder_denominator_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!reset_n_in);
	sequence s_req; $rose(avs_read_in | avs_write_in); endsequence
	sequence s_ans; avs_waitrequest_out ##1 !avs_waitrequest_out; endsequence
	a_one_wait: assert property (s_req |-> s_ans) else $error("wait count");
	a_idle_wait: assert property (!avs_read_in && !avs_write_in |-> !avs_waitrequest_out)
		else $error("idle wait");
	a_sel_hold: assert property (!$past(avs_write_in) |->
		$stable({negative_select_out, positive_select_out})) else $error("select moved");
	a_lad_quarter: assert property ($stable({ladder_range_out, ladder_tap_out}) &&
		ladder_range_out == 2'h0 |-> ladder_denominator_out == 6'h20 &&
		ladder_numerator_out == ladder_tap_out + 6'h09) else $error("quarter ladder");
	a_lad_fifth: assert property ($stable({ladder_range_out, ladder_tap_out}) &&
		ladder_range_out == 2'h2 |-> ladder_denominator_out == 6'h28 &&
		ladder_numerator_out == ladder_tap_out + 6'h09) else $error("fifth ladder");
	a_lad_span: assert property (32 * ladder_numerator_out >= ladder_denominator_out &&
		4 * ladder_numerator_out <= 3 * ladder_denominator_out) else $error("ladder span");
	a_irq_cause: assert property ($rose(irq_out) |-> $past(avs_write_in) ||
		$past(avs_write_in, 2) || $past(avs_write_in, 3) ||
		$past(comparator_raw_in, 3) != $past(comparator_raw_in, 4) ||
		$past(comparator_raw_in, 4) != $past(comparator_raw_in, 5)) else $error("irq cause");
	a_irq_sticky: assert property (irq_out && !avs_read_in && !avs_write_in |=> irq_out)
		else $error("irq dropped");
endmodule // acmp_top_sva
bind acmp_top acmp_top_sva acmp_top_sva_i (.*);

// file: sim/acmp_analog_model.sv
`timescale 1ns/1ps
// analog far side in millivolts, pin6 tied low
// analog pins carry no digital buffer load
module acmp_analog_model (
	input  wire [2:0] neg_sel_in,
	input  wire       pos_sel_in,
	input  wire [5:0] num_in,
	input  wire [5:0] den_in,
	input  int        pin3_mv_in,
	input  int        pin4_mv_in,
	input  int        vdd_mv_in,
	output logic      raw_out
);
	int lad;
	int neg;
	always_comb begin
		lad = vdd_mv_in * num_in / den_in;
		neg = neg_sel_in == 3'h0 ? pin3_mv_in : neg_sel_in == 3'h1 ? pin4_mv_in :
			neg_sel_in == 3'h2 ? 1200 : neg_sel_in == 3'h3 ? lad : 0;
		raw_out = (pos_sel_in ? pin4_mv_in : lad) > neg;
	end
endmodule // acmp_analog_model

// file: sim/acmp_top_tb_top.sv
`timescale 1ns/1ps
module acmp_top_tb_top;
	logic clk_in, reset_n_in, avs_read_in, avs_write_in, gpio_pin0_out_in;
	logic timer2_sample_clock_in, gpio_pin0_oe_n_in;
	logic [4:0] avs_address_in;
	logic [3:0] avs_byteenable_in;
	logic [31:0] avs_writedata_in;
	wire [31:0] avs_readdata_out;
	wire avs_waitrequest_out, irq_out, comparator_enable_out, comparator_raw_in;
	wire positive_select_out, port_a_pin0_out, port_a_pin0_oe_n_out, comparator_result_bit_out;
	wire [2:0] negative_select_out;
	wire [1:0] ladder_range_out;
	wire [3:0] ladder_tap_out;
	wire [5:0] ladder_numerator_out, ladder_denominator_out;
	int p3 = 2000, n_mismatch = 0, comparisons = 0;
	logic [7:0] q;
	acmp_top acmp_top_i (.*);
	acmp_analog_model acmp_analog_model_i (.neg_sel_in(negative_select_out),
		.pos_sel_in(positive_select_out), .num_in(ladder_numerator_out),
		.den_in(ladder_denominator_out), .pin3_mv_in(p3), .pin4_mv_in(3000),
		.vdd_mv_in(4000), .raw_out(comparator_raw_in));
	initial begin
		clk_in = 1'b0;
		forever #4 clk_in = ~clk_in;
	end
	task report_and_stop(input int hung);
		n_mismatch += hung;
		$display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
		if (n_mismatch == 0 && comparisons > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task chk(input logic [31:0] s, input logic [31:0] e);
		comparisons++;
		if (s !== e) begin
			n_mismatch++;
			$display("wrong value at %0t: %h not %h", $time, s, e);
		end
	endtask
	task bus(input logic w, input logic [4:0] a, input logic [7:0] d);
		int k;
		avs_address_in <= a;
		avs_writedata_in <= {24'h000000, d};
		avs_write_in <= w;
		avs_read_in <= !w;
		k = 0;
		do begin
			@(negedge clk_in);
			k++;
		end while (avs_waitrequest_out !== 1'b0 && k < 50);
		if (k >= 50) report_and_stop(1);
		@(posedge clk_in);
		q = avs_readdata_out[7:0];
		avs_write_in <= 1'b0;
		avs_read_in <= 1'b0;
		@(posedge clk_in);
	endtask
	task w6(); repeat (6) @(posedge clk_in); endtask
	task tick();
		timer2_sample_clock_in <= 1'b1;
		@(posedge clk_in);
		timer2_sample_clock_in <= 1'b0;
		w6();
	endtask
	task s_case1();
		bus(1'b0, 5'h14, 8'h00);
		chk(q, 8'h00);
		bus(1'b1, 5'h04, 8'h09);
		bus(1'b1, 5'h00, 8'h80);
		w6();
		chk({negative_select_out, positive_select_out, ladder_numerator_out}, 10'h012);
		chk(comparator_enable_out, 1'b1);
		bus(1'b0, 5'h00, 8'h00);
		chk(q, 8'hc0);
	endtask
	task s_case2();
		bus(1'b1, 5'h04, 8'had);
		bus(1'b1, 5'h00, 8'h97);
		w6();
		chk({negative_select_out, positive_select_out, ladder_numerator_out}, 10'h1d6);
		chk({ladder_denominator_out, port_a_pin0_oe_n_out, port_a_pin0_out}, 8'ha0);
		bus(1'b0, 5'h00, 8'h00);
		chk(q, 8'h97);
		bus(1'b1, 5'h04, 8'h2d);
		chk({port_a_pin0_oe_n_out, port_a_pin0_out}, 2'h3);
	endtask
	task s_supply();
		int n, f;
		f = 99;
		bus(1'b1, 5'h00, 8'h84);
		for (n = 15; n >= 0; n--) begin
			bus(1'b1, 5'h04, {4'h2, n[3:0]});
			w6();
			bus(1'b0, 5'h00, 8'h00);
			if (q[6] === 1'b1) f = n;
		end
		chk(f, 4);
		for (n = 0; n < 5; n++) begin
			bus(1'b1, 5'h00, {4'h8, n[2:0], 1'b0});
			chk(negative_select_out, n);
		end
		bus(1'b1, 5'h04, 8'h1f);
		w6();
		chk({ladder_numerator_out, ladder_denominator_out}, 12'h418);
		bus(1'b1, 5'h04, 8'h30);
		w6();
		chk({ladder_numerator_out, ladder_denominator_out}, 12'h060);
	endtask
	task s_irq();
		bus(1'b1, 5'h04, 8'h09);
		bus(1'b1, 5'h00, 8'h80);
		bus(1'b1, 5'h0c, 8'h01);
		w6();
		bus(1'b0, 5'h08, 8'h00);
		chk(irq_out, 1'b0);
		p3 <= 2500;
		w6();
		chk(irq_out, 1'b1);
		bus(1'b0, 5'h08, 8'h00);
		chk({q, irq_out}, 9'h002);
		bus(1'b1, 5'h0c, 8'h00);
		p3 <= 2000;
		w6();
		bus(1'b0, 5'h08, 8'h00);
		chk({q, irq_out}, 9'h002);
	endtask
	task s_sample();
		bus(1'b1, 5'h10, 8'h01);
		w6();
		chk(comparator_result_bit_out, 1'b0);
		tick();
		chk(comparator_result_bit_out, 1'b1);
		p3 <= 2500;
		w6();
		chk(comparator_result_bit_out, 1'b1);
		tick();
		chk(comparator_result_bit_out, 1'b0);
	endtask
	initial begin
		{avs_read_in, avs_write_in, timer2_sample_clock_in} = 3'h0;
		{gpio_pin0_out_in, gpio_pin0_oe_n_in} = 2'h3;
		avs_address_in = 5'h00;
		avs_writedata_in = 32'h00000000;
		avs_byteenable_in = 4'hf;
		reset_n_in = 1'b0;
		repeat (3) @(posedge clk_in);
		reset_n_in <= 1'b1;
		@(posedge clk_in);
		s_case1();
		s_case2();
		s_supply();
		s_irq();
		s_sample();
		report_and_stop(0);
	end
endmodule // acmp_top_tb_top
